// ---- hw/dbl_pkg.sv ----
// Package with mode codes and timing counts for the converter latch controller
package dbl_pkg;
    // System clock period in ns
    localparam int unsigned SYS_CLK_PERIOD_NS = 40;
    // Least write strobe width, ns
    localparam int unsigned STROBE_WIDTH_NS   = 900;
    // Least data setup before strobe rise, ns
    localparam int unsigned DATA_SETUP_NS     = 900;
    // Least data hold after strobe rise, ns
    localparam int unsigned DATA_HOLD_NS      = 50;
    // Least control setup before strobe, ns
    localparam int unsigned CTRL_SETUP_NS     = 1100;
    // Cycle counts, rounded up
    localparam int unsigned STROBE_CYCLES =
        (STROBE_WIDTH_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYCLES =
        (DATA_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned SETUP_CYCLES =
        (CTRL_SETUP_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    // Counter width
    localparam int unsigned CNT_W = 6;
    // Operating modes
    localparam logic [1:0] MODE_DOUBLE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_FLOW   = 2'h2;
    // Controller states, one-hot
    typedef enum logic [4:0] {
        DBL_IDLE  = 5'b0_0001,
        DBL_SETUP = 5'b0_0010,
        DBL_LOAD  = 5'b0_0100,
        DBL_HOLD  = 5'b0_1000,
        DBL_TRANSFER_ENABLE_N  = 5'b1_0000
    } dbl_state_t;
endpackage

// ---- hw/dbl_ctrl.sv ----
// Host controller that drives a double-buffered converter's latch pins
`timescale 1ns/10ps
module dbl_ctrl
    import dbl_pkg::*;
#(
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              i_sys_clk,               // System clock
    input  wire logic              i_rst_n,                 // Sync reset, low
    input  wire logic              i_clk_en,                // Freezes all state
    input  wire logic              i_req_valid,             // Write request
    input  wire logic [DATA_W-1:0] i_req_data,              // Code to load
    input  wire logic              i_req_update,            // Also transfer
    input  wire logic [1:0]        i_mode,                  // Buffering mode
    input  wire logic              i_freeze,                // Freeze device
    input  wire logic              i_transfer_enable_n_req,              // Transfer only
    output logic                   o_req_ready,             // Idle, can take
    output logic                   o_done,                  // Sequence done
    output logic [DATA_W-1:0]      o_digital_input_bits,    // Data pins
    output logic                   o_chip_select_n,         // Chip select
    output logic                   o_input_latch_enable,    // Input enable
    output logic                   o_input_write_strobe_n,  // First strobe
    output logic                   o_transfer_write_strobe_n, // Second strobe
    output logic                   o_transfer_enable_n      // Transfer enable
);
    // Sequence walk, one state per step, all counts at 40 ns per cycle:
    //   take  - request taken in idle, data pins and mode registered
    //   setup - chip select low ahead of the strobe, control setup met
    //   load  - first strobe low for the full least strobe width
    //   hold  - strobe high again, select and data kept for hold time
    //   transfer_enable_n  - second strobe and transfer enable low together
    //   idle  - done pulses for one enabled cycle
    // A transfer-only request skips load and hold and goes from setup
    // Straight to transfer_enable_n. Many devices may share the transfer lines, so a
    // Single transfer_enable_n phase moves every loaded input register at once.
    // Devices that were not loaded keep their old code across it.
    //
    // Mode notes:
    //   double - input and converter registers are each pulsed
    //   single - transfer lines and select sit low, the converter
    //            Register follows, and the first strobe alone latches
    //   flow   - every active-low control sits low, both registers follow data
    // The mode is latched per request, so a mode change takes effect
    // Only on the next taken request, never in mid-sequence.
    //
    // Hazards and limits:
    //   - The freeze input lowers only the input latch enable and req ready; the
    //     Sequence still runs, so a frozen write is simply lost
    //   - Requests outside idle are dropped without any indication
    //   - The clock enable stops every flop, so pins stand as they are
    //   - Counters compare with greater-or-equal so a stray count can
    //     Never lock a phase open
    //   - Outputs are always driven, so no device pin floats to one
    // Trade-off: phase lengths are whole cycles rounded up, which costs
    // A little throughput but keeps every timing margin positive.

    // Sequencer state and phase counter
    dbl_state_t       state;
    dbl_state_t       next_state;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       mode;       // Mode latched per request
    logic             do_update;  // Transfer after load
    logic             only_transfer_enable_n;  // Transfer-only sequence

    // Phase length done flags
    wire cnt_setup = (cnt >= CNT_W'(SETUP_CYCLES - 1));
    wire cnt_pulse = (cnt >= CNT_W'(STROBE_CYCLES - 1));
    wire cnt_hold  = (cnt >= CNT_W'(HOLD_CYCLES));
    wire is_idle   = (state == DBL_IDLE);
    wire take_req  = is_idle && i_clk_en && (i_req_valid || i_transfer_enable_n_req);
    wire flow      = (mode == MODE_FLOW);

    // Next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            DBL_IDLE:  if (take_req) next_state = DBL_SETUP;
            DBL_SETUP: if (cnt_setup) next_state = only_transfer_enable_n ? DBL_TRANSFER_ENABLE_N : DBL_LOAD;
            DBL_LOAD:  if (cnt_pulse) next_state = DBL_HOLD;
            DBL_HOLD:  if (cnt_hold) begin
                // Single mode transfer already open, no second pulse
                next_state = (do_update && mode == MODE_DOUBLE) ? DBL_TRANSFER_ENABLE_N : DBL_IDLE;
            end
            DBL_TRANSFER_ENABLE_N:  if (cnt_pulse) next_state = DBL_IDLE;
        endcase
    end

    // State, counter and request capture
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state                <= DBL_IDLE;
            cnt                  <= '0;
            mode                 <= MODE_DOUBLE;
            do_update            <= 1'b0;
            only_transfer_enable_n            <= 1'b0;
            o_digital_input_bits <= '0;
            o_done               <= 1'b0;
        end else if (i_clk_en) begin
            state  <= next_state;
            cnt    <= (next_state != state) ? '0 : cnt + CNT_W'(1);
            o_done <= (state != DBL_IDLE) && (next_state == DBL_IDLE);
            if (take_req) begin
                mode      <= i_mode;
                do_update <= i_req_update;
                only_transfer_enable_n <= !i_req_valid;
                // Data held steady through strobe and hold time
                if (i_req_valid) begin
                    o_digital_input_bits <= i_req_data;
                end
            end
        end
    end

    // Pin decode: all controls are levels
    // Every pin is driven at all times, none left floating
    // Input select and transfer select kept as separate lines
    assign o_req_ready = is_idle && !i_freeze;
    // Enable tied high unless frozen
    assign o_input_latch_enable = !i_freeze;
    // Select open in setup, load and hold, setup also for transfer-only; single and flow modes keep it low
    assign o_chip_select_n =
        !(flow || mode == MODE_SINGLE || state == DBL_SETUP
          || state == DBL_LOAD || state == DBL_HOLD);
    // Rising edge at end of LOAD latches the data
    assign o_input_write_strobe_n = !(flow || state == DBL_LOAD);
    // Single and flow modes keep converter register transparent
    assign o_transfer_write_strobe_n =
        !(flow || mode == MODE_SINGLE || state == DBL_TRANSFER_ENABLE_N);
    // Converter register closed outside transfer_enable_n keeps the old code
    assign o_transfer_enable_n =
        !(flow || mode == MODE_SINGLE || state == DBL_TRANSFER_ENABLE_N);

    // Checks
    load_width_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && $fell(o_input_write_strobe_n) && !flow) |->
        (!o_input_write_strobe_n) [*2]) else $error("write strobe too short");
    load_qual_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == DBL_LOAD) |-> !o_chip_select_n) else $error("strobe unqualified");
    data_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && $rose(o_input_write_strobe_n)) |=> $stable(o_digital_input_bits))
        else $error("data changed at latch");
    transfer_enable_n_order_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == DBL_TRANSFER_ENABLE_N) |-> o_input_write_strobe_n) else $error("strobes overlap");
    single_open_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode == MODE_SINGLE) |-> !o_transfer_enable_n && !o_transfer_write_strobe_n)
        else $error("single mode transfer closed");
    flow_open_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        flow |-> !o_chip_select_n && !o_input_write_strobe_n && !o_transfer_enable_n)
        else $error("flow-through not open");
    freeze_pin_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_freeze |-> !o_input_latch_enable && !o_req_ready) else $error("freeze ignored");
    idle_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (is_idle && mode == MODE_DOUBLE) |-> o_input_write_strobe_n && o_transfer_write_strobe_n)
        else $error("strobe active while idle");

    // Single mode holds the select low with the transfer lines
    single_select_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode == MODE_SINGLE) |-> !o_chip_select_n)
        else $error("single mode select high");

    // Transfer phase opens both converter register controls
    transfer_enable_n_pins_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == DBL_TRANSFER_ENABLE_N) |-> !o_transfer_write_strobe_n && !o_transfer_enable_n)
        else $error("transfer phase not open");

    // Double mode transfer uses its own select, input select released
    transfer_enable_n_desel_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == DBL_TRANSFER_ENABLE_N && mode == MODE_DOUBLE) |-> o_chip_select_n)
        else $error("input select during transfer");

    // Enable stays high unless frozen
    enable_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_freeze |-> o_input_latch_enable)
        else $error("latch enable low unfrozen");

    // Clock enable low stops the sequencer and the data pins
    clken_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_clk_en |=> $stable(state) && $stable(o_digital_input_bits))
        else $error("state moved while disabled");

    // Data pins stand through load and hold
    load_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && (state == DBL_LOAD || state == DBL_HOLD)) |=>
        $stable(o_digital_input_bits))
        else $error("data moved during load");

    // Done is a single enabled cycle
    done_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_done && i_clk_en) |=> !o_done)
        else $error("done longer than one cycle");

    // Second pulse only follows a load in double mode
    transfer_enable_n_after_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state == DBL_HOLD && next_state == DBL_TRANSFER_ENABLE_N) |-> (mode == MODE_DOUBLE))
        else $error("transfer pulse outside double mode");

    // Double mode never opens both strobes at once
    strobe_sep_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (mode == MODE_DOUBLE) |-> (o_input_write_strobe_n || o_transfer_write_strobe_n))
        else $error("both strobes low");

    // Idle without a request leaves the data pins alone
    idle_data_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (is_idle && i_clk_en && !take_req) |=> $stable(o_digital_input_bits))
        else $error("data moved while idle");
endmodule

// ---- testbench/dbl_conv_model.sv ----
// Behavioural model of the double-latched converter's digital front end
`timescale 1ns/10ps
module dbl_conv_model (
    input  wire logic [7:0] i_digital_input_bits,      // Data pins, bit 0 is LSB
    input  wire logic       i_chip_select_n,           // Chip select, low
    input  wire logic       i_input_latch_enable,      // Input latch enable, high
    input  wire logic       i_input_write_strobe_n,    // First strobe, low
    input  wire logic       i_transfer_write_strobe_n, // Second strobe, low
    input  wire logic       i_transfer_enable_n,       // Transfer enable, low
    output logic [7:0]      o_code                     // Code seen by the ladder
);
    logic [7:0] in_reg; // Input register, holds the next word
    // Open by level; closing on the strobe rise keeps the data then present
    always_latch begin
        if (!i_chip_select_n && i_input_latch_enable && !i_input_write_strobe_n) begin
            in_reg <= i_digital_input_bits;
        end
    end
    // Converter register keeps its code until both transfer lines are low
    always_latch begin
        if (!i_transfer_write_strobe_n && !i_transfer_enable_n) begin
            o_code <= in_reg;
        end
    end
endmodule

// ---- testbench/dbl_ctrl_tb_top.sv ----
// Self-checking bench for the converter latch controller
`timescale 1ns/10ps
module dbl_ctrl_tb_top import dbl_pkg::*;;
    logic       i_sys_clk = 1'b0; // 25 MHz clock
    logic       i_rst_n = 1'b0;   // Reset, low
    logic       i_req_valid = 1'b0, i_req_update = 1'b0, i_freeze = 1'b0, i_transfer_enable_n_req = 1'b0;
    logic [7:0] i_req_data = 8'h00; // Word to send
    logic [1:0] i_mode = 2'h0;      // Buffering mode
    logic       i_clk_en = 1'b1;    // Clock enable
    wire logic  o_req_ready, o_done, cs_n, in_en, ld_n, mv_n, xe_n; // Controller pins
    wire logic [7:0] bits, code;    // Data pins and converted code
    int         n_fail = 0, samples_checked = 0; // Mismatches, comparisons
    // Half period of 20 ns
    always #20 i_sys_clk = ~i_sys_clk;
    dbl_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
        .i_req_valid(i_req_valid), .i_req_data(i_req_data), .i_req_update(i_req_update),
        .i_mode(i_mode), .i_freeze(i_freeze), .i_transfer_enable_n_req(i_transfer_enable_n_req),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_digital_input_bits(bits),
        .o_chip_select_n(cs_n), .o_input_latch_enable(in_en), .o_input_write_strobe_n(ld_n),
        .o_transfer_write_strobe_n(mv_n), .o_transfer_enable_n(xe_n));
    dbl_conv_model u_conv (.i_digital_input_bits(bits), .i_chip_select_n(cs_n),
        .i_input_latch_enable(in_en), .i_input_write_strobe_n(ld_n),
        .i_transfer_write_strobe_n(mv_n), .i_transfer_enable_n(xe_n), .o_code(code));
    // Compare with case equality so unknowns fail
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("fails %0d checks %0d", n_fail, samples_checked);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One request (write or transfer only), then a bounded wait for done
    task automatic run(input logic wr, input logic [7:0] d, input logic up, input logic [1:0] m);
        int k;
        k = 0;
        @(posedge i_sys_clk);
        #1;
        i_req_valid = wr;
        i_transfer_enable_n_req = !wr;
        i_req_data = d;
        i_req_update = up;
        i_mode = m;
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b0;
        i_transfer_enable_n_req = 1'b0;
        while (o_done !== 1'b1 && k < 300) begin
            @(posedge i_sys_clk);
            #2;
            k++;
        end
        if (k == 300) chk(8'h01, 8'h00);
    endtask
    // Clock enable low in mid-load freezes the pins; load then ends
    task automatic t_clken();
        int k;
        k = 0;
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b1;
        i_req_data = 8'h77;
        i_req_update = 1'b0;
        i_mode = MODE_DOUBLE;
        @(posedge i_sys_clk);
        #1;
        i_req_valid = 1'b0;
        repeat (35) @(posedge i_sys_clk);
        #1;
        i_clk_en = 1'b0;
        chk({7'h00, ld_n}, 8'h00);
        repeat (60) @(posedge i_sys_clk);
        #1;
        chk({7'h00, ld_n}, 8'h00);
        chk({7'h00, o_done}, 8'h00);
        i_clk_en = 1'b1;
        while (o_done !== 1'b1 && k < 300) begin
            @(posedge i_sys_clk);
            #2;
            k++;
        end
        if (k == 300) chk(8'h01, 8'h00);
        chk(code, 8'h80);
    endtask
    // Load without transfer keeps old code; shared transfer moves it
    task automatic t_double();
        run(1'b1, 8'hA5, 1'b1, MODE_DOUBLE);
        chk(code, 8'hA5);
        run(1'b1, 8'h5A, 1'b0, MODE_DOUBLE);
        chk(code, 8'hA5);
        run(1'b0, 8'h00, 1'b0, MODE_DOUBLE);
        chk(code, 8'h5A);
        run(1'b1, 8'h01, 1'b1, MODE_DOUBLE);
        chk(code, 8'h01);
        run(1'b1, 8'h80, 1'b1, MODE_DOUBLE);
        chk(code, 8'h80);
    endtask
    // Enable low blocks writes even across a transfer
    task automatic t_freeze();
        i_freeze = 1'b1;
        run(1'b1, 8'hFF, 1'b1, MODE_DOUBLE);
        chk({7'h00, in_en}, 8'h00);
        chk({7'h00, o_req_ready}, 8'h00);
        chk(code, 8'h80);
        i_freeze = 1'b0;
        run(1'b0, 8'h00, 1'b0, MODE_DOUBLE);
        chk(code, 8'h80);
        chk({7'h00, o_req_ready}, 8'h01);
    endtask
    // Single buffered updates on the first strobe; flow-through follows pins
    task automatic t_modes();
        run(1'b1, 8'h3C, 1'b0, MODE_SINGLE);
        chk(code, 8'h3C);
        chk({4'h0, cs_n, mv_n, xe_n, 1'b0}, 8'h00);
        run(1'b1, 8'hC3, 1'b0, MODE_FLOW);
        chk(code, 8'hC3);
        chk({4'h0, cs_n, ld_n, mv_n, xe_n}, 8'h00);
    endtask
    // Reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge i_sys_clk);
        #1;
        i_rst_n = 1'b1;
        chk({4'h0, cs_n, ld_n, mv_n, xe_n}, 8'h0F);
        chk(bits, 8'h00);
        t_double();
        t_freeze();
        t_clken();
        t_modes();
        conclude();
    end
    // Watchdog well past the roughly 700 cycles the tests need
    initial begin
        #120000;
        n_fail++;
        conclude();
    end
endmodule
